// ---- rtl/servo_input_status_regs.sv ----
// The APB register port was decided locally.
`timescale 1ns/1ps

// Contract
// - after startup the fitted expansion module is detected and reported as 0 none, 1 digital, 2 analogue.
// - the module-dependent status fields follow the type code in the module type register, whether it was detected or written by software.
// - the eight digital inputs of the digital module appear in status bits 7 to 0.
// - every set bit of the 16-bit polarity mask inverts the matching status bit.
// - the four differential line levels appear in status bits 15 to 12.
// - multifunction 1 channel B is bit 13 and multifunction 2 channel A is bit 14.
// - bits 10 to 8 are set while the matching analogue level is above 5.0 volts.
// - the unconditioned second analogue input is bit 10, the conditioned first is bit 9.
// - the routing setup can put a conditioned analogue input onto the primary status bit.
module servo_input_status_regs
(
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [servo_input_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                    pwdata,
   output logic      [31:0]                    prdata,
   output logic                                pready,
   output logic                                pslverr,
   input  wire logic [1:0]                     module_sense,
   input  wire logic [7:0]                     expansion_din,
   input  wire logic [3:0]                     diff_line,
   input  wire logic                           primary_analogue_above,
   input  wire logic                           conditioned_analogue_one_above,
   input  wire logic                           unconditioned_analogue_two_above,
   input  wire logic                           conditioned_analogue_two_above,
   output logic      [15:0]                    expansion_module_type_out,
   output logic                                module_detected
);
   import servo_input_pkg::*;

   logic [15:0]  hardware_input_word_10;
   logic [15:0]  hardware_input_word_11;
   logic [15:0]  expansion_module_type;
   logic [15:0]  digital_input_status;
   logic [15:0]  input_polarity;
   logic [1:0]   io_routing_setup;
   logic [15:0]  detected_type;
   logic         detect_done;
   logic [15:0]  next_status;
   logic         primary_analogue_status;
   logic         setup_phase;
   logic         wr_en;
   logic [7:0]   reg_index;
   logic         addr_ok;
   logic [15:0]  read_word;

   module_type_detect u_detect
   (
      .pclk          (pclk),
      .presetn       (presetn),
      .module_sense  (module_sense),
      .detected_type (detected_type),
      .detect_done   (detect_done)
   );

   // register decode: word aligned, index above the two low address bits
   assign reg_index   = 8'(paddr[ADDR_W-1:2]);
   assign setup_phase = psel && !penable;
   assign wr_en       = setup_phase && pwrite && addr_ok;

   always_comb
   begin
      addr_ok = (paddr[1:0] == 2'h0) &&
                ((reg_index == IDX_HW_INPUT_WORD_10)  ||
                 (reg_index == IDX_HW_INPUT_WORD_11)  ||
                 (reg_index == IDX_EXP_MODULE_TYPE)   ||
                 (reg_index == IDX_DIGITAL_IN_STATUS) ||
                 (reg_index == IDX_INPUT_POLARITY)    ||
                 (reg_index == IDX_IO_ROUTING_SETUP));
   end

   // primary analogue status source selection
   always_comb
   begin
      unique case (io_routing_setup)
         ROUTE_COND_ONE: primary_analogue_status = conditioned_analogue_one_above;
         ROUTE_COND_TWO: primary_analogue_status = conditioned_analogue_two_above;
         default:        primary_analogue_status = primary_analogue_above;
      endcase
   end

   // assemble the raw status word, then apply the polarity mask
   always_comb
   begin
      next_status = 16'h0000;
      if (expansion_module_type == TYPE_DIGITAL_IO)
         next_status[POS_DIGITAL_LO +: 8] = expansion_din;
      next_status[POS_PRIMARY_ANA]    = primary_analogue_status;
      next_status[POS_COND_ANA_ONE]   = conditioned_analogue_one_above;
      next_status[POS_UNCOND_ANA_TWO] = unconditioned_analogue_two_above;
      next_status[POS_DIFF_LO +: 4]   = diff_line;
      next_status[POS_MF1_CHAN_B]     = diff_line[POS_MF1_CHAN_B - POS_DIFF_LO];
      next_status[POS_MF2_CHAN_A]     = diff_line[POS_MF2_CHAN_A - POS_DIFF_LO];
      next_status = next_status ^ input_polarity;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         digital_input_status <= RST_WORD;
      else
         digital_input_status <= next_status;
   end

   // module type: loaded once by detection, software may overwrite afterwards
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         expansion_module_type <= TYPE_NONE;
      else if (detect_done)
         expansion_module_type <= detected_type;
      else if (wr_en && (reg_index == IDX_EXP_MODULE_TYPE))
         expansion_module_type <= pwdata[15:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         module_detected <= 1'b0;
      else if (detect_done)
         module_detected <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         expansion_module_type_out <= TYPE_NONE;
      else
         expansion_module_type_out <= expansion_module_type;
   end

   // plain software words
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hardware_input_word_10 <= RST_WORD;
         hardware_input_word_11 <= RST_WORD;
         input_polarity         <= RST_WORD;
         io_routing_setup       <= RST_ROUTING;
      end
      else if (wr_en)
      begin
         if (reg_index == IDX_HW_INPUT_WORD_10)
            hardware_input_word_10 <= pwdata[15:0];
         if (reg_index == IDX_HW_INPUT_WORD_11)
            hardware_input_word_11 <= pwdata[15:0];
         if (reg_index == IDX_INPUT_POLARITY)
            input_polarity <= pwdata[15:0];
         if (reg_index == IDX_IO_ROUTING_SETUP)
            io_routing_setup <= pwdata[1:0];
      end
   end

   // read mux
   always_comb
   begin
      read_word = 16'h0000;
      if (reg_index == IDX_HW_INPUT_WORD_10)
         read_word = hardware_input_word_10;
      else if (reg_index == IDX_HW_INPUT_WORD_11)
         read_word = hardware_input_word_11;
      else if (reg_index == IDX_EXP_MODULE_TYPE)
         read_word = expansion_module_type;
      else if (reg_index == IDX_DIGITAL_IN_STATUS)
         read_word = digital_input_status;
      else if (reg_index == IDX_INPUT_POLARITY)
         read_word = input_polarity;
      else if (reg_index == IDX_IO_ROUTING_SETUP)
         read_word = {14'h0000, io_routing_setup};
   end

   // answer in the first access cycle: no wait states
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else
      begin
         pready  <= setup_phase;
         pslverr <= setup_phase && !addr_ok;
         if (setup_phase && !pwrite && addr_ok)
            prdata <= {16'h0000, read_word};
         else
            prdata <= 32'h00000000;
      end
   end

endmodule // servo_input_status_regs

// ---- rtl/servo_input_pkg.sv ----
package servo_input_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_HW_INPUT_WORD_10   = 8'h03;
   localparam logic [7:0]  IDX_HW_INPUT_WORD_11   = 8'h04;
   localparam logic [7:0]  IDX_EXP_MODULE_TYPE    = 8'h05;
   localparam logic [7:0]  IDX_DIGITAL_IN_STATUS  = 8'h06;
   localparam logic [7:0]  IDX_INPUT_POLARITY     = 8'h07;
   localparam logic [7:0]  IDX_IO_ROUTING_SETUP   = 8'h08;

   localparam int          ADDR_W                 = 10;

   // reset values
   localparam logic [15:0] RST_WORD               = 16'h0000;
   localparam logic [1:0]  RST_ROUTING            = 2'h0;

   // module type codes
   localparam logic [15:0] TYPE_NONE              = 16'h0000;
   localparam logic [15:0] TYPE_DIGITAL_IO        = 16'h0001;
   localparam logic [15:0] TYPE_ANALOGUE          = 16'h0002;

   // raw sense pin codes of the fitted module
   localparam logic [1:0]  SENSE_NONE             = 2'h0;
   localparam logic [1:0]  SENSE_DIGITAL_IO       = 2'h1;

   // routing selections of the primary analogue status bit
   localparam logic [1:0]  ROUTE_DEFAULT          = 2'h0;
   localparam logic [1:0]  ROUTE_COND_ONE         = 2'h1;
   localparam logic [1:0]  ROUTE_COND_TWO         = 2'h2;

   // status word field positions
   localparam int          POS_DIGITAL_LO         = 0;
   localparam int          POS_PRIMARY_ANA        = 8;
   localparam int          POS_COND_ANA_ONE       = 9;
   localparam int          POS_UNCOND_ANA_TWO     = 10;
   localparam int          POS_DIFF_LO            = 12;
   localparam int          POS_MF1_CHAN_B         = 13;
   localparam int          POS_MF2_CHAN_A         = 14;

   // startup settling time before the sense pins are trusted
   localparam int          CLK_PERIOD_PS          = 25000;
   localparam int          SETTLE_TIME_NS         = 10000;
   localparam int          SETTLE_CYCLES          = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                                    / CLK_PERIOD_PS;
   localparam int          SETTLE_W               = 9;

endpackage

// ---- rtl/module_type_detect.sv ----
`timescale 1ns/1ps

module module_type_detect
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [1:0]  module_sense,
   output logic [15:0]      detected_type,
   output logic             detect_done
);
   import servo_input_pkg::*;

   typedef enum logic [1:0] {ST_SETTLE, ST_CONFIRM, ST_DONE} detect_state_t;

   detect_state_t          state;
   logic [SETTLE_W-1:0]    settle_cnt;
   logic [1:0]             first_sample;

   // wait for the sense pins to settle, then take two agreeing samples
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state        <= ST_SETTLE;
         settle_cnt   <= '0;
         first_sample <= 2'h0;
      end
      else
      begin
         unique case (state)
            ST_SETTLE:
            begin
               if (settle_cnt == SETTLE_W'(SETTLE_CYCLES - 1))
               begin
                  state        <= ST_CONFIRM;
                  first_sample <= module_sense;
               end
               else
               begin
                  settle_cnt <= settle_cnt + SETTLE_W'(1);
               end
            end
            ST_CONFIRM:
            begin
               if (module_sense == first_sample)
               begin
                  state <= ST_DONE;
               end
               else
               begin
                  first_sample <= module_sense;
               end
            end
            ST_DONE:
            begin
               state <= ST_DONE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         detected_type <= TYPE_NONE;
         detect_done   <= 1'b0;
      end
      else
      begin
         detect_done <= (state == ST_CONFIRM) && (module_sense == first_sample);
         if ((state == ST_CONFIRM) && (module_sense == first_sample))
         begin
            if (first_sample == SENSE_NONE)
               detected_type <= TYPE_NONE;
            else if (first_sample == SENSE_DIGITAL_IO)
               detected_type <= TYPE_DIGITAL_IO;
            else
               detected_type <= TYPE_ANALOGUE;
         end
      end
   end

endmodule // module_type_detect

// ---- dv/servo_input_status_properties.sv ----
`timescale 1ns/1ps

module servo_input_status_checker
(
   input wire logic                                pclk,
   input wire logic                                presetn,
   input wire logic                                psel,
   input wire logic                                penable,
   input wire logic [servo_input_pkg::ADDR_W-1:0]  paddr,
   input wire logic [31:0]                         prdata,
   input wire logic                                pready,
   input wire logic                                pslverr,
   input wire logic [1:0]                          module_sense,
   input wire logic [15:0]                         expansion_module_type_out,
   input wire logic                                module_detected
);
   import servo_input_pkg::*;
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   int          cnt;
   logic        setup;
   logic        bad;
   logic [15:0] code;
   assign setup = psel & ~penable;
   assign bad = paddr[1:0] != 2'h0 || paddr[9:2] < 8'h03 || paddr[9:2] > 8'h08;
   assign code = module_sense == SENSE_NONE ? TYPE_NONE :
                 module_sense == SENSE_DIGITAL_IO ? TYPE_DIGITAL_IO : TYPE_ANALOGUE;
   // cycles since reset release, saturating
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) cnt <= 0;
      else if (cnt < 1000) cnt <= cnt + 1;
   end
   chk_setup_answer: assert property (setup |=> pready) else $error("no answer after setup");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   chk_err_unmapped: assert property (setup && bad |=> pslverr) else $error("unmapped not refused");
   chk_ok_mapped: assert property (setup && !bad |=> !pslverr) else $error("mapped refused");
   chk_err_alone: assert property (pslverr |-> pready) else $error("error without ready");
   chk_idle_data: assert property (!pready |-> prdata == 32'h0) else $error("idle data not zero");
   chk_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0) else $error("upper data set");
   chk_detect_settle: assert property (module_detected |-> cnt >= SETTLE_CYCLES)
      else $error("detection before settle time");
   chk_detect_code: assert property ($rose(module_detected) |-> ##[0:2]
      expansion_module_type_out == code) else $error("detected type code wrong");
   chk_detect_hold: assert property (module_detected |=> module_detected)
      else $error("detected flag dropped");
   cov_read: cover property (setup && !bad ##1 pready);
   cov_error: cover property (pslverr);
   cov_detect: cover property ($rose(module_detected));
endmodule // servo_input_status_checker

bind servo_input_status_regs servo_input_status_checker chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .module_sense(module_sense),
   .expansion_module_type_out(expansion_module_type_out), .module_detected(module_detected));

// ---- dv/input_source.sv ----
`timescale 1ns/1ps

module input_source
(
   input  wire logic  pclk,
   output logic [1:0] module_sense,
   output logic [7:0] expansion_din,
   output logic [3:0] diff_line,
   output logic [3:0] analogue_above
);
   // analogue_above: comparator outputs, 0 primary, 1 cond one, 2 uncond two, 3 cond two
   initial
   begin
      module_sense = 2'h0;
      {analogue_above, diff_line, expansion_din} = 16'h0000;
   end
   // called just after a rising edge
   task put(input logic [1:0] s, input logic [15:0] v);
      module_sense <= s;
      {analogue_above, diff_line, expansion_din} <= v;
   endtask
endmodule // input_source

// ---- dv/tb.sv ----
`timescale 1ns/1ps

module tb;
   import servo_input_pkg::*;
   logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0, prdata;
   logic [1:0]        sense;
   logic [7:0]        din;
   logic [3:0]        dl, an;
   logic [15:0]       ty_out;
   logic              det, err;
   int                n_fail = 0, num_checks = 0, seed = 39, cyc = 0;
   always #12.5 pclk = ~pclk;
   input_source src_u (.pclk(pclk), .module_sense(sense), .expansion_din(din),
      .diff_line(dl), .analogue_above(an));
   servo_input_status_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .module_sense(sense), .expansion_din(din),
      .diff_line(dl), .primary_analogue_above(an[0]), .conditioned_analogue_one_above(an[1]),
      .unconditioned_analogue_two_above(an[2]), .conditioned_analogue_two_above(an[3]),
      .expansion_module_type_out(ty_out), .module_detected(det));
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         n_fail++;
         report_and_stop();
      end
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   task apb(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // wait for the answer; only the bench timeout ends a hang
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input logic [7:0] i, input logic [31:0] d);
      logic [31:0] r;
      apb(1, {i, 2'b00}, d, r);
   endtask
   task rd(input logic [7:0] i, output logic [31:0] r);
      apb(0, {i, 2'b00}, $random(seed), r);
   endtask
   // v packs {analogue above [3:0], differential lines, digital inputs}
   function logic [15:0] exp_stat(logic [15:0] ty, logic [15:0] v, logic [1:0] rt,
      logic [15:0] m);
      logic b8;
      b8 = rt == ROUTE_COND_ONE ? v[13] : rt == ROUTE_COND_TWO ? v[15] : v[12];
      return {v[11:8], 1'b0, v[14], v[13], b8, ty == TYPE_DIGITAL_IO ? v[7:0] : 8'h00} ^ m;
   endfunction
   // every sense code once; the status test reuses the first three type codes
   logic [1:0]  sv[4] = '{SENSE_NONE, 2'h3, SENSE_DIGITAL_IO, 2'h2};
   logic [15:0] ec[4] = '{TYPE_NONE, TYPE_ANALOGUE, TYPE_DIGITAL_IO, TYPE_ANALOGUE};
   logic [7:0]  ri[4] = '{IDX_HW_INPUT_WORD_10, IDX_HW_INPUT_WORD_11, IDX_INPUT_POLARITY,
                          IDX_IO_ROUTING_SETUP};
   logic [9:0]  ba[3] = '{10'h000, 10'h00D, 10'h024};
   initial
   begin
      logic [31:0] r, d;
      logic [15:0] m, v, ty, e;
      logic [1:0]  rt;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge pclk);
         presetn <= 0;
         src_u.put(sv[i], 16'h0000);
         repeat (8) @(posedge pclk);
         presetn <= 1;
         for (int k = 0; k < 1000 && det !== 1'b1; k++) @(posedge pclk);
         chk("detected", 1, det);
         rd(IDX_EXP_MODULE_TYPE, r);
         chk("type", ec[i], r);
         chk("type_out", ec[i], ty_out);
      end
      $display("test detect done");
      foreach (ri[i])
      begin
         rd(ri[i], r);
         chk("reset value", 0, r);
      end
      for (int i = 0; i < 2; i++)
      begin
         d = $random(seed);
         wr(ri[i], d);
         rd(ri[i], r);
         chk("word readback", {16'h0, d[15:0]}, r);
      end
      foreach (ba[i])
      begin
         apb(i[0], ba[i], 32'hFFFF, r);
         chk("refused", 1, err);
      end
      $display("test registers done");
      for (int i = 0; i < 24; i++)
      begin
         ty = ec[i % 3];
         m = i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : 16'($random(seed));
         v = i == 2 ? 16'hFFFF : 16'($random(seed));
         rt = 2'($random(seed));
         wr(IDX_EXP_MODULE_TYPE, {16'h0, ty});
         wr(IDX_INPUT_POLARITY, {16'h0, m});
         wr(IDX_IO_ROUTING_SETUP, {30'h0, rt});
         wr(IDX_DIGITAL_IN_STATUS, $random(seed));
         src_u.put(SENSE_DIGITAL_IO, v);
         rd(IDX_DIGITAL_IN_STATUS, r);
         e = exp_stat(ty, v, rt, m);
         chk("status din", {24'h0, e[7:0]}, {24'h0, r[7:0]});
         chk("status ana", {29'h0, e[10:8]}, {29'h0, r[10:8]});
         chk("status lines", {28'h0, e[15:12]}, {28'h0, r[15:12]});
         chk("status word", {16'h0, e}, r);
      end
      $display("test status done");
      report_and_stop();
   end
endmodule // tb
